// ==== rtl/wbr_pkg.sv ====
// Package: constants, field layouts and carrier types of the watchdog and brown-out reset block
package wbr_pkg;

   // Timing
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
   localparam int unsigned POWERUP_DELAY_TIMER_MS        = 72;
   localparam int unsigned POWERUP_DELAY_TIMER_CYCLES    = POWERUP_DELAY_TIMER_MS * 1_000_000 / CLK_PERIOD_NS;
   localparam int unsigned WDT_PERIOD_US  = 18_000;
   localparam int unsigned WDT_OSC_KHZ    = 1_000;
   localparam int unsigned WDT_OSC_TICKS  = WDT_PERIOD_US * WDT_OSC_KHZ / 1_000;
   localparam int unsigned MIN_DIP_NS     = 100_000;
   localparam int unsigned MIN_DIP_CYCLES = (MIN_DIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 32;

   // Register indices; byte address is four times the index
   localparam int unsigned ADDR_W         = 16;
   localparam logic [15:0] IDX_OPTION     = 16'h0081;
   localparam logic [15:0] IDX_CONFIG     = 16'h2007;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h0090;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h0091;
   localparam logic [15:0] IDX_STATE      = 16'h0092;

   // Field positions and reset values
   localparam int unsigned OPT_PSA_BIT    = 3;
   localparam int unsigned OPT_PS_LSB     = 0;
   localparam int unsigned CFG_BOR_BIT    = 6;
   localparam int unsigned CFG_POWERUP_DELAY_TIMER_BIT   = 3;
   localparam int unsigned CFG_WDT_BIT    = 2;
   localparam logic [7:0]  CFG_IMPL_MASK  = 8'h7f;
   localparam logic [7:0]  OPTION_RST     = 8'hff;
   localparam int unsigned IRQ_W          = 3;
   localparam int unsigned IRQ_EXPIRY     = 0;
   localparam int unsigned IRQ_DIP        = 1;
   localparam int unsigned IRQ_WAKE       = 2;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;

   // Supervisor states, Gray along hold, delay, run, sleep
   typedef enum logic [1:0] {
      ST_HOLD  = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN   = 2'b11,
      ST_SLEEP = 2'b10
   } wbr_state_t;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } wbr_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } wbr_axi_rsp_t;

   function automatic logic [ADDR_W-1:0] wbr_byte_addr(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction

   // Terminal count of the shared prescaler: 1:2^ps for the watchdog, 1:2^(ps+1) for the timer
   function automatic logic [7:0] wbr_ratio_mask(input logic [2:0] ps, input logic for_timer);
      logic [8:0] one_hot;
      one_hot = for_timer ? (9'h002 << ps) : (9'h001 << ps);
      return 8'(one_hot - 9'h001);
   endfunction

endpackage

// ==== rtl/wbr_dip_filter.sv ====
// Supply-dip persistence filter for the brown-out reset
`timescale 1ns/1ps
`default_nettype none
module wbr_dip_filter #(
   parameter int unsigned DIP_CYCLES = wbr_pkg::MIN_DIP_CYCLES
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Comparator
   input  wire logic enable,
   input  wire logic supply_low,
   // Result
   output logic      dip_trip
);
   import wbr_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             trip;
   } wbr_dip_st_t;

   wbr_dip_st_t st_q;
   wbr_dip_st_t st_d;

   always_comb begin
      st_d = st_q;
      if (!enable || !supply_low) begin
         st_d.cnt  = '0;                                   // RULE_01
         st_d.trip = 1'b0;                                 // RULE_02
      end else if (st_q.cnt >= CNT_W'(DIP_CYCLES)) begin
         st_d.trip = 1'b1;                                 // RULE_02
      end else begin
         st_d.cnt = st_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dip_trip = st_q.trip;

endmodule
`default_nettype wire

// ==== rtl/wbr_wdt_core.sv ====
// Watchdog counter and the shared eight-bit prescaler
`timescale 1ns/1ps
`default_nettype none
module wbr_wdt_core #(
   parameter int unsigned OSC_TICKS = wbr_pkg::WDT_OSC_TICKS
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Control
   input  wire logic       wdt_enable,
   input  wire logic       wdt_clear,
   input  wire logic       prescaler_assign_select,
   input  wire logic [2:0] ps,
   // Watchdog oscillator level
   input  wire logic       wdt_osc,
   // Timer side of the prescaler
   input  wire logic       timer_event,
   input  wire logic       timer_clear,
   output logic            timer_tick,
   // Expiry pulse
   output logic            expiry
);
   import wbr_pkg::*;

   typedef struct packed {
      logic             osc_prev;
      logic [CNT_W-1:0] base;
      logic [7:0]       pre;
      logic             expiry;
      logic             timer_tick;
   } wbr_wdt_st_t;

   wbr_wdt_st_t st_q;
   wbr_wdt_st_t st_d;
   logic        osc_edge;
   logic        wdt_ovf;

   always_comb begin
      st_d            = st_q;
      osc_edge        = wdt_osc && !st_q.osc_prev;
      wdt_ovf         = 1'b0;
      st_d.osc_prev   = wdt_osc;
      st_d.expiry     = 1'b0;
      st_d.timer_tick = 1'b0;
      // Runs on oscillator edges only, so it keeps going while the core sleeps
      if (wdt_clear || !wdt_enable) begin
         st_d.base = '0;                                   // RULE_08 RULE_11
      end else if (osc_edge) begin                         // RULE_06
         if (st_q.base >= CNT_W'(OSC_TICKS - 1)) begin
            st_d.base = '0;                                // RULE_16
            wdt_ovf   = 1'b1;                              // RULE_09
         end else begin
            st_d.base = st_q.base + 1'b1;
         end
      end
      if (prescaler_assign_select) begin
         st_d.timer_tick = timer_event;                    // RULE_14
         if (wdt_clear || !wdt_enable) begin
            st_d.pre = '0;                                 // RULE_11
         end else if (wdt_ovf) begin
            if (st_q.pre >= wbr_ratio_mask(ps, 1'b0)) begin
               st_d.pre    = '0;
               st_d.expiry = 1'b1;                         // RULE_10 RULE_16
            end else begin
               st_d.pre = st_q.pre + 1'b1;
            end
         end
      end else begin
         st_d.expiry = wdt_ovf;                            // RULE_09 RULE_14
         if (timer_clear) begin
            st_d.pre = '0;
         end else if (timer_event) begin
            if (st_q.pre >= wbr_ratio_mask(ps, 1'b1)) begin
               st_d.pre        = '0;
               st_d.timer_tick = 1'b1;
            end else begin
               st_d.pre = st_q.pre + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign expiry     = st_q.expiry;
   assign timer_tick = st_q.timer_tick;

endmodule
`default_nettype wire

// ==== rtl/wbr_supervisor.sv ====
// Top of the watchdog and brown-out reset supervisor with its AXI4-Lite registers
// Summary of operation
// RULE_01: Brown-out logic works only when its fuse set.
// RULE_02: Reset chip only when dip outlasts minimum duration.
// RULE_03: Hold reset until supply good, then delay.
// RULE_04: Dip during delay returns to hold, restarts delay.
// RULE_05: Fuse programmer keeps delay enabled with brown-out.
// RULE_06: Watchdog counts its own oscillator, also asleep.
// RULE_07: Expiry resets when running, wakes when asleep.
// RULE_08: Cleared watchdog fuse disables watchdog entirely.
// RULE_09: Unscaled expiry period is a parameter count.
// RULE_10: Assigned prescaler extends period, up to 1:128.
// RULE_11: Clear and sleep strobes zero counter, and prescaler when assigned to watchdog.
// RULE_12: Expiry clears the expiry status flag.
// RULE_13: Delay timer skipped when its disable fuse set.
// RULE_14: One prescaler serves timer or watchdog, not both.
// RULE_15: Assignment and ratio come from option low nibble.
// RULE_16: Expiry is one-cycle pulse; counting restarts from zero.
`timescale 1ns/1ps
`default_nettype none
module wbr_supervisor #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = wbr_pkg::POWERUP_DELAY_TIMER_CYCLES,
   parameter int unsigned DIP_CYCLES  = wbr_pkg::MIN_DIP_CYCLES,
   parameter int unsigned OSC_TICKS   = wbr_pkg::WDT_OSC_TICKS
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Register bus
   input  wire wbr_pkg::wbr_axi_req_t axi_req,
   output wbr_pkg::wbr_axi_rsp_t      axi_rsp,
   // Fuses and supply comparator
   input  wire logic [7:0]            fuse_word,
   input  wire logic                  supply_low,
   // Core strobes
   input  wire logic                  watchdog_clear_instruction,
   input  wire logic                  sleep_instruction,
   input  wire logic                  timer_event,
   input  wire logic                  timer_reg_write,
   // Watchdog oscillator
   input  wire logic                  wdt_osc,
   // Results
   output logic                       chip_reset,
   output logic                       wake_up,
   output logic                       expiry_status_flag,
   output logic                       timer_tick,
   output logic                       irq
);
   import wbr_pkg::*;

   typedef struct packed {
      wbr_state_t        state;
      logic [CNT_W-1:0]  delay_cnt;
      logic [7:0]        fuses;
      logic              fuse_taken;
      logic [7:0]        option;
      logic [IRQ_W-1:0]  irq_status;
      logic [IRQ_W-1:0]  irq_mask;
      logic              irq;
      logic              expiry_flag;
      logic              wake;
      logic              chip_reset;
      logic              aw_hold;
      logic [ADDR_W-1:0] awaddr;
      logic              w_hold;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      wbr_axi_rsp_t      rsp;
   } wbr_top_st_t;

   localparam wbr_top_st_t ST_RST = '{
      state       : ST_HOLD,
      option      : OPTION_RST,
      expiry_flag : 1'b1,
      chip_reset  : 1'b1,
      default     : '0
   };

   wbr_top_st_t      st_q;
   wbr_top_st_t      st_d;
   logic             bor_en;
   logic             powerup_delay_timer_dis;
   logic             wdt_en;
   logic             dip_trip;
   logic             expiry;
   logic             wdt_clear;
   logic             in_reset;
   logic [IRQ_W-1:0] events;
   logic [IRQ_W-1:0] w1c;

   assign bor_en   = st_q.fuses[CFG_BOR_BIT];              // RULE_01
   assign powerup_delay_timer_dis = st_q.fuses[CFG_POWERUP_DELAY_TIMER_BIT];             // RULE_13
   assign wdt_en   = st_q.fuses[CFG_WDT_BIT];              // RULE_08
   assign in_reset = (st_q.state == ST_HOLD) || (st_q.state == ST_DELAY);
   // Counter held at zero through reset so every run after a reset of two or more cycles starts with a full period
   assign wdt_clear = in_reset ||
                      ((st_q.state == ST_RUN) && (watchdog_clear_instruction || sleep_instruction)); // RULE_11

   wbr_dip_filter #(
      .DIP_CYCLES (DIP_CYCLES)
   ) u_dip (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (bor_en && st_q.fuse_taken),
      .supply_low (supply_low),
      .dip_trip   (dip_trip)
   );

   wbr_wdt_core #(
      .OSC_TICKS (OSC_TICKS)
   ) u_wdt (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .wdt_enable  (wdt_en && st_q.fuse_taken),
      .wdt_clear   (wdt_clear),
      .prescaler_assign_select         (st_q.option[OPT_PSA_BIT]),            // RULE_15
      .ps          (st_q.option[OPT_PS_LSB +: 3]),        // RULE_15
      .wdt_osc     (wdt_osc),
      .timer_event (timer_event),
      .timer_clear (timer_reg_write),
      .timer_tick  (timer_tick),
      .expiry      (expiry)
   );

   always_comb begin
      st_d      = st_q;
      events    = '0;
      w1c       = '0;
      st_d.wake = 1'b0;

      // Fuses are caught once, in the first cycle after reset release
      if (!st_q.fuse_taken) begin
         st_d.fuses      = fuse_word & CFG_IMPL_MASK;
         st_d.fuse_taken = 1'b1;
      end

      case (st_q.state)
         ST_HOLD: begin
            if (st_q.fuse_taken && !(bor_en && supply_low)) begin     // RULE_03
               st_d.delay_cnt = '0;
               st_d.state     = powerup_delay_timer_dis ? ST_RUN : ST_DELAY;         // RULE_13
            end
         end
         ST_DELAY: begin
            if (bor_en && supply_low) begin
               st_d.state     = ST_HOLD;                              // RULE_04
               st_d.delay_cnt = '0;
            end else if (st_q.delay_cnt >= CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
               st_d.state = ST_RUN;                                   // RULE_03
            end else begin
               st_d.delay_cnt = st_q.delay_cnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (dip_trip) begin
               st_d.state      = ST_HOLD;                             // RULE_02
               events[IRQ_DIP] = 1'b1;
            end else if (expiry) begin
               st_d.state = ST_HOLD;                                  // RULE_07
            end else if (sleep_instruction) begin
               st_d.state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (dip_trip) begin
               st_d.state      = ST_HOLD;                             // RULE_02
               events[IRQ_DIP] = 1'b1;
            end else if (expiry) begin
               st_d.state       = ST_RUN;                             // RULE_07
               st_d.wake        = 1'b1;
               events[IRQ_WAKE] = 1'b1;
            end
         end
         default: begin
            st_d.state = ST_HOLD;
         end
      endcase
      st_d.chip_reset = (st_d.state == ST_HOLD) || (st_d.state == ST_DELAY);

      // Expiry status flag: cleared by expiry, set again by clear and sleep strobes
      if (expiry) begin
         st_d.expiry_flag   = 1'b0;                                   // RULE_12
         events[IRQ_EXPIRY] = 1'b1;
      end else if (wdt_clear && !in_reset) begin
         st_d.expiry_flag = 1'b1;
      end

      // Write channels are taken independently, then joined
      if (st_q.rsp.bvalid && axi_req.bready) begin
         st_d.rsp.bvalid = 1'b0;
      end
      if (st_q.rsp.awready && axi_req.awvalid) begin
         st_d.aw_hold = 1'b1;
         st_d.awaddr  = axi_req.awaddr;
      end
      if (st_q.rsp.wready && axi_req.wvalid) begin
         st_d.w_hold = 1'b1;
         st_d.wdata  = axi_req.wdata;
         st_d.wstrb  = axi_req.wstrb;
      end
      if (st_d.aw_hold && st_d.w_hold && !st_q.rsp.bvalid) begin
         st_d.aw_hold    = 1'b0;
         st_d.w_hold     = 1'b0;
         st_d.rsp.bvalid = 1'b1;
         st_d.rsp.bresp  = RESP_OKAY;
         if (st_d.awaddr == wbr_byte_addr(IDX_OPTION)) begin
            if (st_d.wstrb[0]) begin
               st_d.option = st_d.wdata[7:0];                         // RULE_15
            end
         end else if (st_d.awaddr == wbr_byte_addr(IDX_IRQ_STATUS)) begin
            w1c = st_d.wdata[IRQ_W-1:0] & {IRQ_W{st_d.wstrb[0]}};
         end else if (st_d.awaddr == wbr_byte_addr(IDX_IRQ_MASK)) begin
            if (st_d.wstrb[0]) begin
               st_d.irq_mask = st_d.wdata[IRQ_W-1:0];
            end
         end else if (st_d.awaddr == wbr_byte_addr(IDX_CONFIG) ||
                      st_d.awaddr == wbr_byte_addr(IDX_STATE)) begin
            st_d.rsp.bresp = RESP_OKAY;
         end else begin
            st_d.rsp.bresp = RESP_DECERR;
         end
      end
      st_d.rsp.awready = !st_d.aw_hold && !st_d.rsp.bvalid;
      st_d.rsp.wready  = !st_d.w_hold && !st_d.rsp.bvalid;

      // The option register returns to its reset value with every chip reset
      if (st_q.state == ST_HOLD) begin
         st_d.option = OPTION_RST;
      end

      // Read channel, one read in flight
      if (st_q.rsp.rvalid && axi_req.rready) begin
         st_d.rsp.rvalid = 1'b0;
      end
      if (st_q.rsp.arready && axi_req.arvalid) begin
         st_d.rsp.rvalid = 1'b1;
         st_d.rsp.rresp  = RESP_OKAY;
         st_d.rsp.rdata  = '0;
         if (axi_req.araddr == wbr_byte_addr(IDX_OPTION)) begin
            st_d.rsp.rdata[7:0] = st_q.option;
         end else if (axi_req.araddr == wbr_byte_addr(IDX_CONFIG)) begin
            st_d.rsp.rdata[7:0] = st_q.fuses;
         end else if (axi_req.araddr == wbr_byte_addr(IDX_IRQ_STATUS)) begin
            st_d.rsp.rdata[IRQ_W-1:0] = st_q.irq_status;
         end else if (axi_req.araddr == wbr_byte_addr(IDX_IRQ_MASK)) begin
            st_d.rsp.rdata[IRQ_W-1:0] = st_q.irq_mask;
         end else if (axi_req.araddr == wbr_byte_addr(IDX_STATE)) begin
            st_d.rsp.rdata[3:0] = {st_q.expiry_flag, st_q.chip_reset, st_q.state};
         end else begin
            st_d.rsp.rresp = RESP_DECERR;
         end
      end
      st_d.rsp.arready = !st_d.rsp.rvalid;

      // Sticky status: an event in the cycle of its clear still sets the bit
      st_d.irq_status = (st_q.irq_status & ~w1c) | events;
      st_d.irq        = |(st_d.irq_status & st_d.irq_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign axi_rsp            = st_q.rsp;
   assign chip_reset         = st_q.chip_reset;
   assign wake_up            = st_q.wake;
   assign expiry_status_flag = st_q.expiry_flag;
   assign irq                = st_q.irq;

endmodule
`default_nettype wire

// ==== bench/wbr_checker.sv ====
// Checker: bus handshakes, reset sequencing and watchdog outcomes of the supervisor
`timescale 1ns/1ps
`default_nettype none
module wbr_checker #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 20,
   parameter int unsigned DIP_CYCLES  = 3
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Register bus
   input  wire wbr_pkg::wbr_axi_req_t axi_req,
   input  wire wbr_pkg::wbr_axi_rsp_t axi_rsp,
   // Fuses and supply
   input  wire logic [7:0]            fuse_word,
   input  wire logic                  supply_low,
   // Results
   input  wire logic                  chip_reset,
   input  wire logic                  wake_up,
   input  wire logic                  expiry_status_flag
);
   import wbr_pkg::*;
   // Reset cycles with a good supply, and length of the current dip
   int unsigned good_q;
   int unsigned low_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || !chip_reset || (supply_low && fuse_word[CFG_BOR_BIT]))
         good_q <= 0;
      else
         good_q <= good_q + 1;
      low_q <= supply_low ? low_q + 1 : 0;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_taken;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence ar_taken;
      axi_req.arvalid && axi_rsp.arready;
   endsequence
   a_write_answer: assert property (aw_w_taken |=> axi_rsp.bvalid)
      else $error("write response missing");
   a_read_answer: assert property (ar_taken |=> axi_rsp.rvalid)
      else $error("read response missing");
   a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data dropped early");
   a_wake_pulse: assert property (wake_up |=> !wake_up)
      else $error("wake pulse longer than one cycle");
   a_wake_outcome: assert property (wake_up |-> !chip_reset && !expiry_status_flag)
      else $error("wake without flag clear or with reset");
   a_wdt_disabled: assert property (!fuse_word[CFG_WDT_BIT] |-> expiry_status_flag && !wake_up)
      else $error("disabled watchdog expired");
   a_delay_min: assert property ($fell(chip_reset) && !fuse_word[CFG_POWERUP_DELAY_TIMER_BIT] |->
      good_q >= POWERUP_DELAY_TIMER_CYCLES)
      else $error("reset released before power-up delay");
   a_delay_max: assert property (good_q <= POWERUP_DELAY_TIMER_CYCLES + 4)
      else $error("reset held too long with good supply");
   a_no_delay: assert property (fuse_word[CFG_POWERUP_DELAY_TIMER_BIT] |-> good_q <= 4)
      else $error("power-up delay ran while disabled");
   a_dip_filter: assert property ($rose(chip_reset) && expiry_status_flag |->
      low_q >= DIP_CYCLES || $past(low_q) >= DIP_CYCLES)
      else $error("reset from a short dip");
endmodule

bind wbr_supervisor wbr_checker #(
   .POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES),
   .DIP_CYCLES (DIP_CYCLES)
) i_chk (
   .aclk              (aclk),
   .aresetn           (aresetn),
   .axi_req           (axi_req),
   .axi_rsp           (axi_rsp),
   .fuse_word         (fuse_word),
   .supply_low        (supply_low),
   .chip_reset        (chip_reset),
   .wake_up           (wake_up),
   .expiry_status_flag(expiry_status_flag)
);
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench: registers, watchdog, sleep wake, brown-out and prescaler of the supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
   import wbr_pkg::*;
   localparam int unsigned PW = 20;
   localparam int unsigned DP = 3;
   localparam int unsigned OT = 4;
   localparam logic [15:0] A_OPT = IDX_OPTION << 2;
   localparam logic [15:0] A_CFG = IDX_CONFIG << 2;
   localparam logic [15:0] A_STA = IDX_IRQ_STATUS << 2;
   localparam logic [15:0] A_MSK = IDX_IRQ_MASK << 2;
   localparam logic [15:0] A_STT = IDX_STATE << 2;
   typedef struct packed {logic wr; logic [15:0] a; logic [31:0] d; logic [1:0] r;} wbr_row_t;
   logic         aclk = 1'h0;
   logic         aresetn = 1'h0;
   logic         sup = 1'h0;
   logic         clr = 1'h0;
   logic         slp = 1'h0;
   logic         tev = 1'h0;
   logic         twr = 1'h0;
   logic         osc = 1'h0;
   logic [7:0]   fuse = 8'h44;
   wbr_axi_req_t req = '0;
   wbr_axi_rsp_t rsp;
   logic         chip_reset, wake, flag, tick, irq;
   logic [1:0]   r;
   logic [31:0]  d;
   int           errors = 0;
   int           num_checks = 0;
   int           tk = 0;
   // Plain bus cases: write flag, address, data or expected read data, response
   wbr_row_t rows [12] = '{
      '{1'h0, A_OPT, 32'hff, RESP_OKAY}, '{1'h1, A_OPT, 32'h0f, RESP_OKAY},
      '{1'h0, A_OPT, 32'h0f, RESP_OKAY}, '{1'h0, A_CFG, 32'h44, RESP_OKAY},
      '{1'h1, A_CFG, 32'h00, RESP_OKAY}, '{1'h0, A_CFG, 32'h44, RESP_OKAY},
      '{1'h0, A_MSK, 32'h00, RESP_OKAY}, '{1'h1, A_MSK, 32'h07, RESP_OKAY},
      '{1'h0, A_MSK, 32'h07, RESP_OKAY}, '{1'h0, A_STT, 32'h0b, RESP_OKAY},
      '{1'h1, 16'h0300, 32'h0, RESP_DECERR}, '{1'h0, 16'h0300, 32'h0, RESP_DECERR}};
   logic [7:0] opts [4] = '{8'h00, 8'h08, 8'h0b, 8'h0f};

   always #10 aclk = ~aclk;
   // Slow oscillator: one tick every two bus clocks
   always @(posedge aclk) osc <= ~osc;
   always @(posedge aclk) if (tick === 1'h1) tk <= tk + 1;

   wbr_supervisor #(.POWERUP_DELAY_TIMER_CYCLES(PW), .DIP_CYCLES(DP), .OSC_TICKS(OT)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .fuse_word(fuse),
      .supply_low(sup), .watchdog_clear_instruction(clr), .sleep_instruction(slp),
      .timer_event(tev), .timer_reg_write(twr), .wdt_osc(osc), .chip_reset(chip_reset),
      .wake_up(wake), .expiry_status_flag(flag), .timer_tick(tick), .irq(irq));

   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input logic [15:0] a, input logic [31:0] v);
      int n;
      @(posedge aclk);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= v;
      req.wstrb <= 4'hf;
      req.bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'h0;
         if (rsp.wready) req.wvalid <= 1'h0;
         if (rsp.bvalid) break;
      end
      req.bready <= 1'h0;
      r = rsp.bvalid ? rsp.bresp : 2'hx;
   endtask
   task rd(input logic [15:0] a);
      int n;
      @(posedge aclk);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'h0;
         if (rsp.rvalid) break;
      end
      req.rready <= 1'h0;
      r = rsp.rvalid ? rsp.rresp : 2'hx;
      d = rsp.rdata;
   endtask
   task wait_run(input int lim, output int n);
      for (n = 0; n < lim && chip_reset !== 1'h0; n++) @(posedge aclk);
   endtask
   task quiet(input int c);
      int bad;
      bad = 0;
      repeat (c) begin
         @(posedge aclk);
         if (chip_reset !== 1'h0 || wake !== 1'h0) bad++;
      end
      chk("no reset or wake", 0, bad);
   endtask
   // Clear held as a level over the write, so a ratio switch cannot expire early
   task expire(input logic [7:0] o, input int e);
      int n;
      clr <= 1'h1;
      wr(A_OPT, {24'h0, o});
      clr <= 1'h0;
      for (n = 0; n < 1200 && flag !== 1'h0; n++) @(posedge aclk);
      chk("expiry delay", 1, n >= e - 2 && n <= e + 6);
      chk("reset on expiry", 1, chip_reset);
      wait_run(60, n);
   endtask

   initial begin
      int n;
      cyc(16);
      aresetn <= 1'h1;
      wait_run(60, n);
      chk("power-up delay", 1, n >= PW && n <= PW + 4);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         else begin
            rd(rows[i].a);
            chk("read data", rows[i].d, d);
         end
         chk("response", rows[i].r, r);
      end
      foreach (opts[i])
         expire(opts[i], 2 * OT * (opts[i][3] ? 32'h1 << opts[i][2:0] : 32'h1));
      wr(A_STA, 32'h7);
      wr(A_MSK, 32'h0);
      wr(A_OPT, 32'h0f);
      @(posedge aclk) slp <= 1'h1;
      @(posedge aclk) slp <= 1'h0;
      for (n = 0; n < 1200 && wake !== 1'h1; n++) @(posedge aclk);
      chk("wake delay", 1, n >= 1022 && n <= 1030);
      chk("reset at wake", 0, chip_reset);
      cyc(2);
      chk("irq masked", 0, irq);
      wr(A_MSK, 32'h4);
      cyc(2);
      chk("irq raised", 1, irq);
      rd(A_STA);
      chk("status", 32'h5, d);
      wr(A_STA, 32'h5);
      cyc(2);
      chk("irq cleared", 0, irq);
      clr <= 1'h1;
      wr(A_OPT, 32'h00);
      repeat (30) begin
         @(posedge aclk) clr <= 1'h1;
         @(posedge aclk) clr <= 1'h0;
         quiet(2);
      end
      // Watchdog kept clear while the timer runs through the prescaler, then bypasses it with the prescaler on the watchdog
      clr <= 1'h1;
      foreach (opts[i]) if (i < 2) begin
         wr(A_OPT, i == 0 ? 32'h01 : 32'h08);
         @(posedge aclk) twr <= 1'h1;
         @(posedge aclk) twr <= 1'h0;
         n = tk;
         repeat (16) begin
            @(posedge aclk) tev <= 1'h1;
            @(posedge aclk) tev <= 1'h0;
         end
         cyc(3);
         chk("timer ticks", i == 0 ? 4 : 16, tk - n);
      end
      @(posedge aclk) sup <= 1'h1;
      cyc(DP);
      sup <= 1'h0;
      quiet(8);
      sup <= 1'h1;
      cyc(DP + 6);
      chk("dip reset", 1, chip_reset);
      sup <= 1'h0;
      cyc(5);
      sup <= 1'h1;
      cyc(2);
      sup <= 1'h0;
      wait_run(60, n);
      chk("delay restart", 1, n >= PW && n <= PW + 4);
      clr <= 1'h0;
      aresetn <= 1'h0;
      fuse <= 8'h08;
      cyc(16);
      aresetn <= 1'h1;
      wait_run(60, n);
      chk("no power-up delay", 1, n <= 4);
      sup <= 1'h1;
      wr(A_OPT, 32'h00);
      quiet(100);
      chk("flag kept", 1, flag);
      report_and_stop;
   end
   initial begin
      cyc(10000);
      errors++;
      $display("[FAIL] run length expected finish seen timeout");
      report_and_stop;
   end
endmodule
`default_nettype wire
